/* File: rtl/cao_ccm.sv */
/*
  one compare module: compare bytes, mode, output pin logic.
  assumes tick is a single-cycle pulse and cnt_new is the counter value
  that the tick produces; cnt_now is the counter before it.
*/
`timescale 1ns/1ps
module cao_ccm import cao_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register writes
  input  wire logic        wr_mode,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // watchdog duty, only ever high for module 5
  input  wire logic        wd_on,
  // timebase
  input  wire logic        tick,
  input  wire logic [15:0] cnt_now,
  input  wire logic [15:0] cnt_new,
  // state
  output logic      [7:0]  mode_q,
  output logic      [7:0]  low_q,
  output logic      [7:0]  high_q,
  output logic             match,
  output logic             pin_q
);
  logic [7:0]    mode_r, low_r, high_r, mode_nxt, low_nxt, high_nxt;
  logic          pin_r, pin_nxt, hso_r;
  cao_ccm_mode_t m;
  logic          hso, freq, pw8, pw16, eq16, eq8, wrap8, wrap16, zero16;

  // effective mode and the four output modes
  assign m      = wd_on ? CAO_WD_FORCE : mode_r;
  assign hso    = m.comparator_enable & m.toggle_enable & m.match_enable
                & ~m.pulse_mod_enable;
  assign freq   = m.comparator_enable & m.toggle_enable & m.pulse_mod_enable;
  assign pw8    = m.comparator_enable & m.pulse_mod_enable & ~m.toggle_enable
                & ~m.wide_pulse_select;
  assign pw16   = m.comparator_enable & m.pulse_mod_enable & ~m.toggle_enable
                & m.wide_pulse_select;
  assign eq16   = cnt_new == {high_r, low_r};
  assign eq8    = cnt_new[7:0] == low_r;
  assign wrap8  = cnt_new[7:0] == 8'h00;
  assign wrap16 = cnt_new == 16'h0000;
  assign zero16 = {high_r, low_r} == 16'h0000;
  assign match  = tick & m.comparator_enable & (m.pulse_mod_enable
                ? (m.wide_pulse_select ? eq16 : eq8) : (m.match_enable & eq16));

  // low byte write clears the comparator, high byte write sets it
  assign mode_nxt = (wr_mode & ~wd_on) ? wdata :
                    wr_low  ? (mode_r & ~(8'h01 << CAO_CM_CMP)) :
                    wr_high ? (mode_r |  (8'h01 << CAO_CM_CMP)) : mode_r;
  // frequency mode steps the low byte by the half period; 0 wraps as 256
  assign low_nxt  = wr_low ? wdata :
                    (tick & freq & eq8)  ? 8'(low_r + high_r) :
                    (tick & pw8 & wrap8) ? high_r : low_r;
  // watchdog update ignores the written value
  assign high_nxt = !wr_high ? high_r :
                    wd_on ? 8'(cnt_now[15:8] + low_r) : wdata;
  // pin: pwm with comparator off forces low first, then entry, then per-mode events
  assign pin_nxt  = (m.pulse_mod_enable & ~m.toggle_enable & ~m.comparator_enable)
                    ? 1'b0 :
                    (hso & ~hso_r) ? 1'b1 :
                    ~tick ? pin_r :
                    ((hso & eq16) | (freq & eq8)) ? ~pin_r :
                    (pw8 & wrap8)  ? (high_r == 8'h00) :
                    (pw8 & eq8)    ? 1'b1 :
                    (pw16 & wrap16) ? zero16 :
                    (pw16 & eq16)  ? 1'b1 : pin_r;

  // module registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= CAO_CCM_RST;
      low_r  <= CAO_CCM_RST;
      high_r <= CAO_CCM_RST;
      pin_r  <= 1'b0;
      hso_r  <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      low_r  <= low_nxt;
      high_r <= high_nxt;
      pin_r  <= pin_nxt;
      hso_r  <= hso;
    end
  end

  assign mode_q = mode_r;
  assign low_q  = low_r;
  assign high_q = high_r;
  assign pin_q  = pin_r;
endmodule : cao_ccm

/* File: rtl/cao_pkg.sv */
/*
  shared constants and field layouts of the counter array compare block.
  assumes byte addresses on a 32-bit apb bus, one register per word.
*/
package cao_pkg;
  // number of compare modules and the one that serves as watchdog
  localparam int          CAO_NMOD        = 6;
  localparam int          CAO_WD_MOD      = 5;
  // register byte offsets
  localparam logic [7:0]  CAO_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  CAO_OFF_MODE    = 8'h04;
  localparam logic [7:0]  CAO_OFF_CNTL    = 8'h08;
  localparam logic [7:0]  CAO_OFF_CNTH    = 8'h0c;
  localparam logic [7:0]  CAO_OFF_CCM     = 8'h10;
  localparam logic [7:0]  CAO_OFF_CCM_END = 8'h70;
  // word index inside one module slot (slot stride 0x10)
  localparam logic [1:0]  CAO_SUB_MODE    = 2'h0;
  localparam logic [1:0]  CAO_SUB_LOW     = 2'h1;
  localparam logic [1:0]  CAO_SUB_HIGH    = 2'h2;
  // field positions
  localparam int          CAO_CTRL_OVF    = 7;
  localparam int          CAO_CTRL_RUN    = 6;
  localparam int          CAO_MD_ENA      = 6;
  localparam int          CAO_MD_LCK      = 5;
  localparam int          CAO_CM_CMP      = 6;
  // values after reset
  localparam logic [7:0]  CAO_MODE_RST    = 8'h40;
  localparam logic [7:0]  CAO_CTRL_RST    = 8'h00;
  localparam logic [7:0]  CAO_CCM_RST     = 8'h00;
  localparam logic [15:0] CAO_CNT_RST     = 16'h0000;
  // module mode while it serves as watchdog: comparator and match only
  localparam logic [7:0]  CAO_WD_FORCE    = 8'h48;
  // prescaler of the divided timebases
  localparam int          CAO_PRESC_DIV   = 12;
  localparam logic [3:0]  CAO_PRESC_LAST  = 4'(CAO_PRESC_DIV - 1);
  localparam logic [1:0]  CAO_DIV4_LAST   = 2'h3;

  // timebase codes
  typedef enum logic [2:0] {
    CAO_TB_DIV12 = 3'h0,
    CAO_TB_DIV4  = 3'h1,
    CAO_TB_TMR0  = 3'h2,
    CAO_TB_EXTIN = 3'h3,
    CAO_TB_SYS   = 3'h4,
    CAO_TB_EXT8  = 3'h5,
    CAO_TB_RTC8  = 3'h6,
    CAO_TB_RSVD  = 3'h7
  } cao_tb_t;

  // module mode register
  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_enable;
    logic cap_pos;
    logic cap_neg;
    logic match_enable;
    logic toggle_enable;
    logic pulse_mod_enable;
    logic module_flag_irq_enable;
  } cao_ccm_mode_t;

  // array mode register
  typedef struct packed {
    logic    idle_suspend_bit;
    logic    watchdog_enable_bit;
    logic    watchdog_lock_bit;
    logic    unused;
    cao_tb_t timebase_select;
    logic    ovf_irq_en;
  } cao_array_mode_t;
endpackage : cao_pkg

/* File: rtl/cao_top.sv */
/*
  counter array with six compare modules and a watchdog on module 5,
  reached over apb. assumes tick inputs are single pulses already on
  pclk; only the external count pin is asynchronous.
*/
`timescale 1ns/1ps
module cao_top import cao_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timebase sources
  input  wire logic        timer0_ovf_tick,
  input  wire logic        ext_div8_tick,
  input  wire logic        rtc_div8_tick,
  input  wire logic        ext_count_pin,
  input  wire logic        cpu_idle,
  // outputs
  output logic      [5:0]  module_io_pin,
  output logic             watchdog_reset
);
  // apb answer registers
  logic [31:0]     prdata_r;
  logic            pready_r, pslverr_r;
  // array registers
  cao_array_mode_t md_r, md_nxt, md_wr;
  logic            run_r, run_nxt, ovf_r, ovf_nxt;
  logic [5:0]      flag_r, flag_nxt;
  logic [15:0]     cnt_r, cnt_nxt, cnt_inc;
  logic [7:0]      snap_r;
  logic [3:0]      presc_r;
  logic            wdrst_r, wdrst_nxt;
  // external count pin: three flops and a filtered level
  logic            ext_s1, ext_s2, ext_s3, ext_lvl_r;
  // per-module wires
  logic [5:0]      wr_cm, wr_lo, wr_hi, match, pin;
  logic [7:0]      cm_q [CAO_NMOD];
  logic [7:0]      lo_q [CAO_NMOD];
  logic [7:0]      hi_q [CAO_NMOD];
  logic [7:0]      ccm_rd [CAO_NMOD];

  // address decode
  logic            setup, wr_en, is_ccm, hit;
  logic            wr_ctrl, wr_mode, wr_cntl, wr_cnth, rd_cntl;
  logic [2:0]      midx;
  logic [1:0]      sub;
  logic [7:0]      wd8, rd_val;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & pready_r;
  // unaligned bytes must not alias onto a module register write
  assign is_ccm  = (paddr >= CAO_OFF_CCM) & (paddr < CAO_OFF_CCM_END)
                 & (paddr[3:2] != 2'h3) & (paddr[1:0] == 2'h0);
  assign hit     = (paddr[1:0] == 2'h0) & (is_ccm | (paddr == CAO_OFF_CTRL)
                 | (paddr == CAO_OFF_MODE) | (paddr == CAO_OFF_CNTL)
                 | (paddr == CAO_OFF_CNTH));
  assign midx    = 3'(paddr[6:4] - 3'h1);
  assign sub     = paddr[3:2];
  assign wd8     = pwdata[7:0];
  assign wr_ctrl = wr_en & (paddr == CAO_OFF_CTRL);
  assign wr_mode = wr_en & (paddr == CAO_OFF_MODE);
  assign wr_cntl = wr_en & (paddr == CAO_OFF_CNTL);
  assign wr_cnth = wr_en & (paddr == CAO_OFF_CNTH);
  assign rd_cntl = setup & ~pwrite & (paddr == CAO_OFF_CNTL);

  // watchdog state and timebase gating
  logic            wd_on, run_eff, suspend, src, tick, ext_fall;
  logic            p12, p4, lo_wrap, wd_hit;

  assign wd_on    = md_r.watchdog_enable_bit | md_r.watchdog_lock_bit;
  assign run_eff  = run_r | wd_on;
  assign suspend  = md_r.idle_suspend_bit & cpu_idle;
  assign p12      = presc_r == CAO_PRESC_LAST;
  assign p4       = presc_r[1:0] == CAO_DIV4_LAST;
  assign ext_fall = ext_lvl_r & ~ext_s3 & ~ext_s2;
  assign src      = (md_r.timebase_select == CAO_TB_DIV12) ? p12 :
                    (md_r.timebase_select == CAO_TB_DIV4)  ? p4 :
                    (md_r.timebase_select == CAO_TB_TMR0)  ? timer0_ovf_tick :
                    (md_r.timebase_select == CAO_TB_EXTIN) ? ext_fall :
                    (md_r.timebase_select == CAO_TB_SYS)   ? 1'b1 :
                    (md_r.timebase_select == CAO_TB_EXT8)  ? ext_div8_tick :
                    (md_r.timebase_select == CAO_TB_RTC8)  ? rtc_div8_tick : 1'b0;
  assign tick     = run_eff & ~suspend & src;
  assign cnt_inc  = 16'(cnt_r + 16'h0001);

  // counter: software may load bytes only with the watchdog off
  assign cnt_nxt = (wr_cntl & ~wd_on) ? {cnt_r[15:8], wd8} :
                   (wr_cnth & ~wd_on) ? {wd8, cnt_r[7:0]} :
                   tick ? cnt_inc : cnt_r;

  // array mode: with the watchdog on only an unlocked disable or a lock set gets through
  assign md_wr  = wd_on
                ? {md_r[7], md_r.watchdog_enable_bit & (md_r.watchdog_lock_bit
                   | wd8[CAO_MD_ENA] | wd8[CAO_MD_LCK]),
                   md_r.watchdog_lock_bit | wd8[CAO_MD_LCK], md_r[4:0]}
                : {wd8[7], wd8[CAO_MD_ENA] | wd8[CAO_MD_LCK], wd8[CAO_MD_LCK],
                   1'b0, wd8[3:0]};
  assign md_nxt = wr_mode ? md_wr : md_r;

  // run bit is stored as written, the watchdog only overrides its effect
  assign run_nxt  = wr_ctrl ? wd8[CAO_CTRL_RUN] : run_r;
  // hardware set wins over a software clear in the same cycle
  assign ovf_nxt  = (tick & (cnt_r == 16'hffff)) | (wr_ctrl ? wd8[CAO_CTRL_OVF] : ovf_r);
  assign flag_nxt = match | (wr_ctrl ? wd8[5:0] : flag_r);

  // watchdog reset: low wrap on an update match, or forced by flag write
  assign lo_wrap   = tick & (cnt_r[7:0] == 8'hff);
  assign wd_hit    = hi_q[CAO_WD_MOD] == cnt_r[15:8];
  assign wdrst_nxt = wd_on & ((lo_wrap & wd_hit)
                   | (wr_ctrl & wd8[CAO_WD_MOD]));

  // read selection
  assign rd_val = (paddr == CAO_OFF_CTRL) ? {ovf_r, run_r, flag_r} :
                  (paddr == CAO_OFF_MODE) ? {md_r[7:5], 1'b0, md_r[3:0]} :
                  (paddr == CAO_OFF_CNTL) ? cnt_r[7:0] :
                  (paddr == CAO_OFF_CNTH) ? snap_r :
                  is_ccm ? ccm_rd[midx] : 8'h00;

  // compare modules
  genvar gi;
  generate
    for (gi = 0; gi < CAO_NMOD; gi++) begin : g_ccm
      assign wr_cm[gi]  = wr_en & is_ccm & (midx == 3'(gi)) & (sub == CAO_SUB_MODE);
      assign wr_lo[gi]  = wr_en & is_ccm & (midx == 3'(gi)) & (sub == CAO_SUB_LOW);
      assign wr_hi[gi]  = wr_en & is_ccm & (midx == 3'(gi)) & (sub == CAO_SUB_HIGH);
      assign ccm_rd[gi] = (sub == CAO_SUB_MODE) ? cm_q[gi] :
                          (sub == CAO_SUB_LOW)  ? lo_q[gi] : hi_q[gi];
      cao_ccm u_ccm (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_mode (wr_cm[gi]),
        .wr_low  (wr_lo[gi]),
        .wr_high (wr_hi[gi]),
        .wdata   (wd8),
        .wd_on   ((gi == CAO_WD_MOD) && wd_on),
        .tick    (tick),
        .cnt_now (cnt_r),
        .cnt_new (cnt_inc),
        .mode_q  (cm_q[gi]),
        .low_q   (lo_q[gi]),
        .high_q  (hi_q[gi]),
        .match   (match[gi]),
        .pin_q   (pin[gi])
      );
    end
  endgenerate

  // apb answer: data latched in setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_val};
      end
    end
  end

  // external count pin synchroniser; level changes once s2 and s3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1    <= 1'b1;
      ext_s2    <= 1'b1;
      ext_s3    <= 1'b1;
      ext_lvl_r <= 1'b1;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_lvl_r <= ext_s3;
      end
    end
  end

  // prescaler runs freely so the divided ticks keep a steady phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 4'h0;
    end else begin
      presc_r <= p12 ? 4'h0 : 4'(presc_r + 4'h1);
    end
  end

  // array state; reset leaves the watchdog on at div12 with zero bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_r    <= CAO_MODE_RST;
      run_r   <= CAO_CTRL_RST[CAO_CTRL_RUN];
      ovf_r   <= CAO_CTRL_RST[CAO_CTRL_OVF];
      flag_r  <= CAO_CTRL_RST[5:0];
      cnt_r   <= CAO_CNT_RST;
      snap_r  <= 8'h00;
      wdrst_r <= 1'b0;
    end else begin
      md_r    <= md_nxt;
      run_r   <= run_nxt;
      ovf_r   <= ovf_nxt;
      flag_r  <= flag_nxt;
      cnt_r   <= cnt_nxt;
      wdrst_r <= wdrst_nxt;
      if (rd_cntl) begin
        snap_r <= cnt_r[15:8];
      end
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign module_io_pin  = pin;
  assign watchdog_reset = wdrst_r;
endmodule : cao_top

/* File: verification/cao_pin_mon.sv */
/*
  load on the module output pins: counts high cycles and level changes of one pin.
  assumes pins are registered on pclk; clr zeroes both counts.
*/
`timescale 1ns/1ps
module cao_pin_mon (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // watched pins and window control
  input  wire logic [5:0]  pins,
  input  wire logic [2:0]  sel,
  input  wire logic        clr,
  // results
  output logic      [15:0] hi_r,
  output logic      [15:0] chg_r
);
  logic prev_r;
  // previous level is tracked during clr too, so the first counted edge is honest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      hi_r   <= 16'h0000;
      chg_r  <= 16'h0000;
    end else begin
      prev_r <= pins[sel];
      hi_r   <= clr ? 16'h0000 : hi_r + 16'(pins[sel]);
      chg_r  <= clr ? 16'h0000 : chg_r + 16'(pins[sel] != prev_r);
    end
  end
endmodule : cao_pin_mon

/* File: verification/cao_top_bench.sv */
/*
  self-checking bench for cao_top: apb tasks, pin windows, watchdog runs.
  assumes one pclk domain; only the system-clock timebases are exercised.
*/
`timescale 1ns/1ps
module cao_top_bench import cao_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wd_rst, mon_clr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pins;
  logic [2:0]  mon_sel;
  logic [15:0] hi_cnt, edge_cnt;
  int          fails = 0, total_checks = 0, cyc = 0, n;
  // unused timebase sources held quiet
  cao_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_ovf_tick(1'b0), .ext_div8_tick(1'b0), .rtc_div8_tick(1'b0),
    .ext_count_pin(1'b1), .cpu_idle(1'b0), .module_io_pin(pins), .watchdog_reset(wd_rst));
  cao_pin_mon mon_u (.pclk(pclk), .presetn(presetn), .pins(pins), .sel(mon_sel),
    .clr(mon_clr), .hi_r(hi_cnt), .chg_r(edge_cnt));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // hang guard; the whole run needs under 10000 cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the hang guard may end a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_wd(input int lim);
    n = 0;
    while (wd_rst !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_wd
  // settle, then count len cycles of one pin
  task automatic window(input logic [2:0] s, input int settle, input int len);
    repeat (settle) @(posedge pclk);
    mon_sel <= s;
    mon_clr <= 1'b1;
    @(posedge pclk);
    mon_clr <= 1'b0;
    repeat (len) @(posedge pclk);
    #1;
  endtask : window
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, fails);
  endtask : done
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mon_clr = 1'b0;
    mon_sel = 3'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // default watchdog: 256 ticks of the divide-by-12 timebase
    wait_wd(3300);
    chk("wd timeout", 1, n >= 3050 && n <= 3100);
    apb(0, CAO_OFF_MODE, 8'h00);
    chk("mode reset", CAO_MODE_RST, rd);
    apb(0, 8'h64, 8'h00);
    chk("wd offset", 8'h00, rd);
    apb(1, CAO_OFF_MODE, 8'h00);
    apb(1, CAO_OFF_MODE, 8'h08);
    apb(0, CAO_OFF_MODE, 8'h00);
    chk("mode off", 8'h08, rd);
    apb(0, 8'hf0, 8'h00);
    chk("unmapped", 1, err);
    apb(1, 8'h12, 8'hff);
    chk("unaligned", 1, err);
    apb(0, 8'h10, 8'h00);
    chk("unaligned ignored", 8'h00, rd);
    done("reset");
    // high speed output on module 0 at count 0x0010, counter stopped at zero
    apb(1, CAO_OFF_CTRL, 8'h00);
    apb(1, CAO_OFF_CNTL, 8'h00);
    apb(1, CAO_OFF_CNTH, 8'h00);
    apb(1, 8'h10, 8'h4c);
    apb(1, 8'h14, 8'h10);
    apb(0, 8'h10, 8'h00);
    chk("cmp after low", 8'h0c, rd);
    apb(1, 8'h18, 8'h00);
    apb(0, 8'h10, 8'h00);
    chk("cmp after high", 8'h4c, rd);
    chk("hso start", 1, pins[0]);
    apb(1, CAO_OFF_CTRL, 8'h40);
    repeat (40) @(posedge pclk);
    chk("hso toggle", 0, pins[0]);
    apb(0, CAO_OFF_CTRL, 8'h00);
    chk("flag0", 1, rd[0]);
    done("hso");
    // 8-bit pwm on module 1: quarter duty, full duty, comparator off
    apb(1, 8'h24, 8'hc0);
    apb(1, 8'h28, 8'hc0);
    apb(1, 8'h20, 8'h42);
    window(1, 600, 512);
    chk("pwm8 quarter", 128, hi_cnt);
    apb(1, 8'h28, 8'h00);
    window(1, 600, 256);
    chk("pwm8 full", 256, hi_cnt);
    apb(1, 8'h24, 8'h00);
    window(1, 600, 256);
    chk("pwm8 off", 0, hi_cnt);
    done("pwm8");
    // frequency output on module 3: half period 4, then 0 meaning 256
    apb(1, 8'h44, 8'h00);
    apb(1, 8'h48, 8'h04);
    apb(1, 8'h40, 8'h46);
    window(3, 300, 64);
    chk("freq edges", 16, edge_cnt);
    apb(1, 8'h48, 8'h00);
    window(3, 600, 512);
    chk("freq 256", 2, edge_cnt);
    done("freq");
    // 16-bit pwm on module 2: compare 0xfff8 from count 0xfff0
    apb(1, CAO_OFF_CTRL, 8'h00);
    apb(1, 8'h34, 8'hf8);
    apb(1, 8'h38, 8'hff);
    apb(1, 8'h30, 8'hc2);
    apb(1, CAO_OFF_CNTL, 8'hf0);
    apb(1, CAO_OFF_CNTH, 8'hff);
    apb(1, CAO_OFF_CTRL, 8'h40);
    window(2, 0, 100);
    chk("pwm16 high", 8, hi_cnt);
    // new compare after one read of the match flag, counter stopped and reloaded to 0xfff0: 0xfffc gives four high cycles
    apb(0, CAO_OFF_CTRL, 8'h00);
    chk("pwm16 flag", 1, rd[2]);
    apb(1, CAO_OFF_CTRL, 8'h00);
    apb(1, 8'h34, 8'hfc);
    apb(1, 8'h38, 8'hff);
    apb(1, CAO_OFF_CNTL, 8'hf0);
    apb(1, CAO_OFF_CNTH, 8'hff);
    apb(1, CAO_OFF_CTRL, 8'h40);
    window(2, 0, 100);
    chk("pwm16 new duty", 4, hi_cnt);
    done("pwm16");
    // watchdog from count 0x0500 with offset 2: expiry at 0x07ff
    apb(1, CAO_OFF_CTRL, 8'h00);
    apb(1, CAO_OFF_CNTL, 8'h00);
    apb(1, CAO_OFF_CNTH, 8'h05);
    apb(1, 8'h64, 8'h02);
    apb(1, CAO_OFF_MODE, 8'h48);
    apb(1, 8'h68, 8'haa);
    apb(0, 8'h68, 8'h00);
    chk("wd update", 8'h07, rd);
    apb(0, CAO_OFF_CTRL, 8'h00);
    chk("run bit", 0, rd[6]);
    apb(1, CAO_OFF_MODE, 8'hca);
    apb(0, CAO_OFF_MODE, 8'h00);
    chk("mode frozen", 8'h48, rd);
    wait_wd(900);
    chk("wd expiry", 1, n > 650 && n < 800);
    apb(1, CAO_OFF_MODE, 8'h20);
    apb(1, CAO_OFF_MODE, 8'h00);
    apb(0, CAO_OFF_MODE, 8'h00);
    chk("locked", 8'h68, rd);
    apb(1, CAO_OFF_CTRL, 8'h20);
    wait_wd(4);
    chk("forced wd", 1, wd_rst);
    chk("spare pins", 2'b00, pins[5:4]);
    done("watchdog");
    report_and_stop();
  end
endmodule : cao_top_bench
bind cao_top cao_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .watchdog_reset(watchdog_reset));

/* File: verification/cao_top_chk.sv */
/*
  port checker for cao_top: apb answer shape and watchdog behaviour.
  assumes one pclk domain and writes landing at the apb access edge.
*/
`timescale 1ns/1ps
module cao_top_chk import cao_pkg::*; (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // watchdog
  input wire logic        watchdog_reset
);
  logic        en_r;
  logic        lk_r;
  logic [3:0]  fz_r;
  logic [11:0] age_r;
  wire         acc_w = psel && penable && pready && pwrite;
  wire         md_w  = acc_w && paddr == CAO_OFF_MODE;
  // shadow of enable, lock and frozen fields; lock only drops at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r  <= 1'b1;
      lk_r  <= 1'b0;
      fz_r  <= 4'h0;
      age_r <= 12'h000;
    end else begin
      if (age_r != 12'hfff) age_r <= age_r + 12'h001;
      if (md_w && pwdata[5]) begin
        en_r <= 1'b1;
        lk_r <= 1'b1;
      end else if (md_w && !lk_r) begin
        en_r <= pwdata[6];
      end
      if (md_w && !en_r) fz_r <= {pwdata[7], pwdata[3:1]};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> psel && penable && pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_unmapped; psel && !penable && paddr >= CAO_OFF_CCM_END |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits not zero");
  property p_force; acc_w && paddr == CAO_OFF_CTRL && pwdata[5] && en_r |-> ##[1:2] watchdog_reset;
  endproperty
  a_force: assert property (p_force) else $error("forced watchdog reset missing");
  property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("watchdog reset not a pulse");
  property p_early; watchdog_reset |-> age_r >= 12'hbb8; endproperty
  a_early: assert property (p_early) else $error("watchdog reset too early");
  property p_lock; lk_r && pready && !pwrite && paddr == CAO_OFF_MODE |-> prdata[6:5] == 2'b11;
  endproperty
  a_lock: assert property (p_lock) else $error("locked watchdog was disabled");
  property p_frozen; en_r && pready && !pwrite && paddr == CAO_OFF_MODE
    |-> {prdata[7], prdata[3:1]} == fz_r; endproperty
  a_frozen: assert property (p_frozen) else $error("frozen mode fields changed");
  c_force: cover property (acc_w && paddr == CAO_OFF_CTRL && pwdata[5] && en_r);
  c_lock: cover property (lk_r && pready && paddr == CAO_OFF_MODE);
  c_err: cover property (pready && pslverr);
endmodule : cao_top_chk
